// *** verilog/sca_pkg.sv ***
// Constants for the subtract-with-carry datapath slice: instruction fields,
// opcodes, register offsets, flag bit positions, reset values and states.
// Assumes instruction bit 0 of the printed layout is the word's MSB (bit 31).
`default_nettype none

package sca_pkg;

  localparam int unsigned DATA_W  = 32;
  localparam int unsigned REGA_W  = 5;
  localparam int unsigned AXI_A_W = 8;

  // Field positions in little-endian numbering of the 32-bit word
  localparam int unsigned OPCD_LSB = 26;
  localparam int unsigned DEST_LSB = 21;
  localparam int unsigned SRCA_LSB = 16;
  localparam int unsigned SRCB_LSB = 11;
  localparam int unsigned WRAP_BIT = 10;
  localparam int unsigned XO_LSB   = 1;
  localparam int unsigned REC_BIT  = 0;

  localparam logic [5:0] OPCD_ARITH   = 6'h1f;
  localparam logic [8:0] XO_SUB_COUT  = 9'h008;
  localparam logic [8:0] XO_SUB_CIN   = 9'h088;

  // Register byte offsets
  localparam logic [AXI_A_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [AXI_A_W-1:0] OFF_EXC      = 8'h04;
  localparam logic [AXI_A_W-1:0] OFF_CR0      = 8'h08;
  localparam logic [AXI_A_W-1:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [AXI_A_W-1:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [AXI_A_W-1:0] OFF_COUNT    = 8'h14;

  localparam int unsigned CTRL_EN  = 0;
  localparam int unsigned EXC_CY   = 0;
  localparam int unsigned EXC_WR   = 1;
  localparam int unsigned EXC_SO   = 2;
  localparam int unsigned CR_SO    = 0;
  localparam int unsigned CR_ZERO  = 1;
  localparam int unsigned CR_POS   = 2;
  localparam int unsigned CR_NEG   = 3;
  localparam int unsigned IRQ_WRAP = 0;
  localparam int unsigned IRQ_ILL  = 1;
  localparam int unsigned IRQ_DONE = 2;
  localparam int unsigned IRQ_W    = 3;

  localparam logic        CTRL_EN_RST = 1'h1;
  localparam logic [2:0]  EXC_RST     = 3'h0;
  localparam logic [3:0]  CR0_RST     = 4'h0;
  localparam logic [2:0]  IRQ_RST     = 3'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_READ = 3'h2,
    ST_WB   = 3'h4
  } sca_state_type;

endpackage : sca_pkg

`default_nettype wire

// *** verilog/sca_top.sv ***
// Subtract-from-carrying / subtract-from-extended datapath slice with an
// AXI4-Lite register slave for the exception flags, condition field 0 and
// interrupts. Assumes a register file with combinational read ports and an
// issue stage on the same clock.
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [RULE1] Opcode 31 with extended opcode 8 writes not(A) + 1 + B to the target register.
// [RULE2] Extended opcode 136 writes carry flag + B + not(A) to the target register.
// [RULE3] Target, first source, second source, wrap-check and record bits come from fixed instruction fields.
// [RULE4] Every form of both instructions updates the carry flag.
// [RULE5] With wrap-check set, the overflow and sticky overflow flags are updated from the result.
// [RULE6] With record set, negative, positive, zero and the sticky copy in condition field 0 are updated.
// [RULE7] Without wrap-check the overflow flags stay; without record condition field 0 stays.
// [RULE8] Operands and result are treated as 32-bit signed two's complement values.
// [RULE9] Carry is the carry out of the top bit; overflow is signed overflow and is ORed into the sticky flag.
// [RULE10] Exactly one of negative, positive, zero is set by signed compare with zero, plus the sticky copy.
module sca_top
(
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic                            issue_valid,
  output logic                                 issue_ready,
  input  wire logic [sca_pkg::DATA_W-1:0]      issue_instr,
  output logic [sca_pkg::REGA_W-1:0]           rd_addr_a,
  output logic [sca_pkg::REGA_W-1:0]           rd_addr_b,
  input  wire logic [sca_pkg::DATA_W-1:0]      rd_data_a,
  input  wire logic [sca_pkg::DATA_W-1:0]      rd_data_b,
  output logic                                 wb_valid,
  output logic [sca_pkg::REGA_W-1:0]           wb_addr,
  output logic [sca_pkg::DATA_W-1:0]           wb_data,
  output logic                                 done,
  output logic                                 illegal,
  output logic                                 irq,
  input  wire logic [sca_pkg::AXI_A_W-1:0]     s_axi_awaddr,
  input  wire logic [2:0]                      s_axi_awprot,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [sca_pkg::AXI_A_W-1:0]     s_axi_araddr,
  input  wire logic [2:0]                      s_axi_arprot,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready
);
  import sca_pkg::*;

  sca_state_type            state_r;
  logic [DATA_W-1:0]        instr_r;
  logic                     legal;
  logic                     exec_fire;
  logic                     wrap_en;
  logic                     rec_en;
  logic                     cin;
  logic [DATA_W:0]          sum;
  logic [DATA_W-1:0]        res;
  logic                     carry;
  logic                     ovf;
  logic                     arith_c_flag_r;
  logic                     signed_wrap_flag_r;
  logic                     so_r;
  logic                     so_base;
  logic                     so_after;
  logic [3:0]               cr0_r;
  logic                     ctrl_en_r;
  logic [IRQ_W-1:0]         irq_stat_r;
  logic [IRQ_W-1:0]         irq_mask_r;
  logic [IRQ_W-1:0]         irq_set;
  logic [DATA_W-1:0]        count_r;
  logic                     wb_valid_r;
  logic [REGA_W-1:0]        wb_addr_r;
  logic [DATA_W-1:0]        wb_data_r;
  logic                     done_r;
  logic                     illegal_r;
  logic                     aw_full_r;
  logic                     w_full_r;
  logic [AXI_A_W-1:0]       aw_addr_r;
  logic [31:0]              w_data_r;
  logic [3:0]               w_strb_r;
  logic                     bvalid_r;
  logic [1:0]               bresp_r;
  logic                     rvalid_r;
  logic [31:0]              rdata_r;
  logic [1:0]               rresp_r;
  logic                     do_wr;
  logic                     wr_hit;
  logic                     sw_exc;
  logic                     sw_cr0;
  logic [31:0]              rd_mux;
  logic                     rd_hit;

  // Instruction sequencing
  assign issue_ready = (state_r == ST_IDLE) && ctrl_en_r;
  assign rd_addr_a   = instr_r[SRCA_LSB +: REGA_W]; // [RULE3]
  assign rd_addr_b   = instr_r[SRCB_LSB +: REGA_W]; // [RULE3]
  assign wrap_en     = instr_r[WRAP_BIT]; // [RULE3]
  assign rec_en      = instr_r[REC_BIT]; // [RULE3]
  assign legal       = (instr_r[OPCD_LSB +: 6] == OPCD_ARITH) &&
                       ((instr_r[XO_LSB +: 9] == XO_SUB_COUT) || (instr_r[XO_LSB +: 9] == XO_SUB_CIN));
  assign exec_fire   = (state_r == ST_READ) && legal;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= ST_IDLE;
      instr_r <= '0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (issue_valid && issue_ready)
          begin
            instr_r <= issue_instr;
            state_r <= ST_READ;
          end
        end
        ST_READ: state_r <= ST_WB;
        ST_WB:   state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Arithmetic
  // One adder serves both forms; only the carry-in differs
  assign cin   = (instr_r[XO_LSB +: 9] == XO_SUB_CIN) ? arith_c_flag_r : 1'h1; // [RULE1] [RULE2]
  assign sum   = {1'h0, ~rd_data_a} + {1'h0, rd_data_b} + {{DATA_W{1'h0}}, cin}; // [RULE1] [RULE2]
  assign res   = sum[DATA_W-1:0];
  assign carry = sum[DATA_W]; // [RULE9]
  // Signed overflow: addends share a sign that the result does not
  assign ovf   = (~rd_data_a[DATA_W-1] == rd_data_b[DATA_W-1]) &&
                 (res[DATA_W-1] != rd_data_b[DATA_W-1]); // [RULE8] [RULE9]

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wb_valid_r <= 1'h0;
      wb_addr_r  <= '0;
      wb_data_r  <= '0;
      done_r     <= 1'h0;
      illegal_r  <= 1'h0;
    end
    else
    begin
      wb_valid_r <= exec_fire;
      done_r     <= (state_r == ST_READ);
      illegal_r  <= (state_r == ST_READ) && !legal;
      if (exec_fire)
      begin
        wb_addr_r <= instr_r[DEST_LSB +: REGA_W]; // [RULE3]
        wb_data_r <= res; // [RULE1] [RULE2]
      end
    end
  end

  assign wb_valid = wb_valid_r;
  assign wb_addr  = wb_addr_r;
  assign wb_data  = wb_data_r;
  assign done     = done_r;
  assign illegal  = illegal_r;

  // Exception flags
  assign sw_exc   = do_wr && (aw_addr_r == OFF_EXC) && w_strb_r[0];
  assign sw_cr0   = do_wr && (aw_addr_r == OFF_CR0) && w_strb_r[0];
  assign so_base  = sw_exc ? w_data_r[EXC_SO] : so_r;
  assign so_after = so_base | (wrap_en & ovf); // [RULE9]

  // The instruction's update wins over a software write in the same cycle;
  // the sticky flag still keeps whatever either side set.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arith_c_flag_r     <= EXC_RST[EXC_CY];
      signed_wrap_flag_r <= EXC_RST[EXC_WR];
      so_r               <= EXC_RST[EXC_SO];
    end
    else
    begin
      if (sw_exc)
      begin
        arith_c_flag_r     <= w_data_r[EXC_CY];
        signed_wrap_flag_r <= w_data_r[EXC_WR];
        so_r               <= w_data_r[EXC_SO];
      end
      if (exec_fire)
      begin
        arith_c_flag_r <= carry; // [RULE4]
        if (wrap_en)
        begin
          signed_wrap_flag_r <= ovf; // [RULE5] [RULE7]
          so_r <= so_after; // [RULE5] [RULE9]
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cr0_r <= CR0_RST;
    else if (exec_fire && rec_en)
    begin
      cr0_r[CR_NEG]  <= res[DATA_W-1]; // [RULE6] [RULE10]
      cr0_r[CR_POS]  <= !res[DATA_W-1] && (res != '0); // [RULE10]
      cr0_r[CR_ZERO] <= (res == '0); // [RULE10]
      cr0_r[CR_SO]   <= wrap_en ? so_after : so_base; // [RULE6] [RULE10]
    end
    else if (sw_cr0)
      cr0_r <= w_data_r[3:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_r <= '0;
    else if (exec_fire)
      count_r <= count_r + 32'h1;
  end

  // Interrupts
  assign irq_set = {(state_r == ST_READ), (state_r == ST_READ) && !legal, exec_fire && wrap_en && ovf};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_r <= IRQ_RST;
    else if (do_wr && (aw_addr_r == OFF_IRQ_STAT) && w_strb_r[0])
      irq_stat_r <= (irq_stat_r & ~w_data_r[IRQ_W-1:0]) | irq_set;
    else
      irq_stat_r <= irq_stat_r | irq_set;
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_mask_r <= IRQ_RST;
      ctrl_en_r  <= CTRL_EN_RST;
    end
    else if (do_wr && w_strb_r[0])
    begin
      if (aw_addr_r == OFF_IRQ_MASK)
        irq_mask_r <= w_data_r[IRQ_W-1:0];
      if (aw_addr_r == OFF_CTRL)
        ctrl_en_r <= w_data_r[CTRL_EN];
    end
  end

  // AXI4-Lite write
  // Address and data are held independently so either may arrive first
  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready  = !w_full_r && !bvalid_r;
  assign do_wr         = aw_full_r && w_full_r && !bvalid_r;
  assign wr_hit        = (aw_addr_r == OFF_CTRL) || (aw_addr_r == OFF_EXC) || (aw_addr_r == OFF_CR0) ||
                         (aw_addr_r == OFF_IRQ_STAT) || (aw_addr_r == OFF_IRQ_MASK) ||
                         (aw_addr_r == OFF_COUNT);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'h0;
      w_full_r  <= 1'h0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid_r  <= 1'h0;
      bresp_r   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_r <= 1'h1;
        aw_addr_r <= {s_axi_awaddr[AXI_A_W-1:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_r <= 1'h1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_full_r <= 1'h0;
        w_full_r  <= 1'h0;
        bvalid_r  <= 1'h1;
        bresp_r   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'h0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // AXI4-Lite read
  always_comb
  begin
    rd_mux = 32'h0;
    rd_hit = 1'h1;
    unique case ({s_axi_araddr[AXI_A_W-1:2], 2'h0})
      OFF_CTRL:     rd_mux[CTRL_EN] = ctrl_en_r;
      OFF_EXC:      rd_mux[2:0] = {so_r, signed_wrap_flag_r, arith_c_flag_r};
      OFF_CR0:      rd_mux[3:0] = cr0_r;
      OFF_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_r;
      OFF_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_r;
      OFF_COUNT:    rd_mux = count_r;
      default:      rd_hit = 1'h0;
    endcase
  end

  assign s_axi_arready = !rvalid_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'h0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'h1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'h0;
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_exec_cout;
    exec_fire && (instr_r[XO_LSB +: 9] == XO_SUB_COUT);
  endsequence

  sequence s_exec_cin;
    exec_fire && (instr_r[XO_LSB +: 9] == XO_SUB_CIN);
  endsequence

  a_cout_result: assert property (s_exec_cout |=> wb_valid && // [RULE1]
    (wb_data == $past(~rd_data_a + rd_data_b + 32'h1)))
    else $error("carrying subtract result wrong");

  a_cin_result: assert property (s_exec_cin |=> wb_valid && // [RULE2]
    (wb_data == $past(~rd_data_a + rd_data_b + {31'h0, arith_c_flag_r})))
    else $error("extended subtract result wrong");

  a_field_decode: assert property ((issue_valid && issue_ready) |-> ##2 // [RULE3]
    (wb_addr == $past(issue_instr[25:21], 2)) || !wb_valid)
    else $error("target field decoded wrong");

  a_carry_update: assert property (exec_fire |=> (arith_c_flag_r == $past(carry))) // [RULE4]
    else $error("carry flag not updated");

  a_wrap_update: assert property ((exec_fire && wrap_en) |=> // [RULE5]
    (signed_wrap_flag_r == $past(ovf)) && (!$past(ovf) || so_r))
    else $error("overflow flags not updated");

  a_cr0_onehot: assert property ((exec_fire && rec_en) |=> $onehot(cr0_r[3:1])) // [RULE6]
    else $error("condition field 0 not one-hot");

  a_wrap_hold: assert property ((exec_fire && !wrap_en && !sw_exc) |=> // [RULE7]
    $stable(signed_wrap_flag_r) && $stable(so_r))
    else $error("overflow flags changed without wrap check");

  a_sign_flag: assert property ((exec_fire && rec_en) |=> // [RULE8]
    (cr0_r[CR_NEG] == $past(res[DATA_W-1])) && (cr0_r[CR_ZERO] == ($past(res) == 32'h0)))
    else $error("sign flags wrong");

  a_sticky_keep: assert property ((so_r && !sw_exc) |=> so_r) // [RULE9]
    else $error("sticky overflow lost");

  a_cr0_copy: assert property ((exec_fire && rec_en) |=> (cr0_r[CR_SO] == so_r)) // [RULE10]
    else $error("sticky copy in field 0 wrong");

endmodule : sca_top

`default_nettype wire

// *** tb/sca_regfile_model.sv ***
// Behavioural general-purpose register file on the far side of the datapath slice.
// Assumes the bench preloads mem by hierarchical reference between instructions.
`timescale 1ns/1ps
`default_nettype none

module sca_regfile_model
(
  input  wire logic                       aclk,
  input  wire logic [sca_pkg::REGA_W-1:0] rd_addr_a,
  input  wire logic [sca_pkg::REGA_W-1:0] rd_addr_b,
  output logic [sca_pkg::DATA_W-1:0]      rd_data_a,
  output logic [sca_pkg::DATA_W-1:0]      rd_data_b,
  input  wire logic                       wb_valid,
  input  wire logic [sca_pkg::REGA_W-1:0] wb_addr,
  input  wire logic [sca_pkg::DATA_W-1:0] wb_data
);
  import sca_pkg::*;
  logic [DATA_W-1:0] mem [0:31];

  // Combinational read ports: the slice samples them in its read cycle
  assign rd_data_a = mem[rd_addr_a];
  assign rd_data_b = mem[rd_addr_b];

  // Plain always so the bench may also preload entries
  always @(posedge aclk)
  begin
    if (wb_valid)
      mem[wb_addr] <= wb_data;
  end
endmodule : sca_regfile_model

`default_nettype wire

// *** tb/subtract_carry_alu_tb_top.sv ***
// Self-checking bench for the subtract-with-carry slice: corner and random instructions,
// register bus, interrupt and refusal checks. Assumes sca_regfile_model feeds the read ports.
`timescale 1ns/1ps
`default_nettype none

module subtract_carry_alu_tb_top;
  import sca_pkg::*;
  // Entries: extended opcode, carry in, first source, second source
  localparam logic [73:0] CT [6] = '{{9'h008, 1'h0, 32'h80007000, 32'h90003000},
    {9'h088, 1'h1, 32'h90003000, 32'h80007000}, {9'h088, 1'h0, 32'h00004500, 32'h80007000},
    {9'h088, 1'h1, 32'h80000000, 32'hefffffff}, {9'h008, 1'h0, 32'h80000000, 32'h00004500},
    {9'h008, 1'h0, 32'h12345678, 32'h12345678}};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        issue_valid = 1'b0;
  logic [31:0] issue_instr = 32'h0;
  logic        issue_ready, wb_valid, done, illegal, irq, awready, wready, bvalid, arready, rvalid;
  logic [4:0]  rd_addr_a, rd_addr_b, wb_addr;
  logic [31:0] rd_data_a, rd_data_b, wb_data, rdata, d, t;
  logic [7:0]  awaddr = 8'h0;
  logic [7:0]  araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] lfsr_q = 32'h00013e74;
  logic        arith_c_m = 1'b0, wrap_m = 1'b0, so_m = 1'b0;
  logic [3:0]  cr_m = 4'h0;
  logic [2:0]  st_m = 3'h0;
  int          err_total = 0;
  int          samples_checked = 0;
  int          legal_n = 0;

  always #5 aclk = ~aclk;

  sca_top DUT (.aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid), .issue_ready(issue_ready),
    .issue_instr(issue_instr), .rd_addr_a(rd_addr_a), .rd_addr_b(rd_addr_b), .rd_data_a(rd_data_a),
    .rd_data_b(rd_data_b), .wb_valid(wb_valid), .wb_addr(wb_addr), .wb_data(wb_data), .done(done),
    .illegal(illegal), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  sca_regfile_model rf (.aclk(aclk), .rd_addr_a(rd_addr_a), .rd_addr_b(rd_addr_b), .rd_data_a(rd_data_a),
    .rd_data_b(rd_data_b), .wb_valid(wb_valid), .wb_addr(wb_addr), .wb_data(wb_data));

  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction : rnd

  // Returns {signed overflow, carry out, result}
  function automatic logic [33:0] sub_exp(input logic [31:0] a, input logic [31:0] b, input logic cin);
    logic [32:0] s;
    s = {1'b0, ~a} + {1'b0, b} + {32'h0, cin};
    return {(~a[31] == b[31]) && (s[31] != b[31]), s};
  endfunction : sub_exp

  function automatic logic sig(input int k);
    case (k)
      0: return bvalid;
      1: return arready;
      2: return rvalid;
      3: return issue_ready;
      default: return done;
    endcase
  endfunction : sig

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic tmo(input string what);
    err_total++;
    $display("Error timeout waiting for %s", what);
    wrap_up();
  endtask : tmo

  // Checked at the falling edge so the value is the one the next rising edge samples
  task automatic wait_hi(input int k);
    int n;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
      if (n > 20) tmo("handshake");
    end while (sig(k) !== 1'b1);
  endtask : wait_hi

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic at, wt, an, wn;
    int n;
    at = 1'b0;
    wt = 1'b0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(at && wt))
    begin
      @(negedge aclk);
      an = awvalid && awready;
      wn = wvalid && wready;
      @(posedge aclk);
      if (an) awvalid <= 1'b0;
      if (wn) wvalid <= 1'b0;
      at = at | an;
      wt = wt | wn;
      n++;
      if (n > 20) tmo("write");
    end
    wait_hi(0);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wait_hi(1);
    @(posedge aclk);
    arvalid <= 1'b0;
    wait_hi(2);
    d = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic setx(input logic [2:0] v);
    axi_wr(OFF_EXC, {29'h0, v});
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
    {so_m, wrap_m, arith_c_m} = v;
  endtask : setx

  task automatic op(input logic [5:0] oc, input logic [8:0] xo, input logic wr, input logic rec,
                    input logic [31:0] a, input logic [31:0] b);
    logic [4:0]  src_a, src_b, dst;
    logic [33:0] e;
    logic        lg;
    t = rnd();
    src_a = t[4:0];
    src_b = src_a + 5'h1 + {1'b0, t[8:5]};
    dst = t[14:10];
    lg = (oc == OPCD_ARITH) && (xo == XO_SUB_COUT || xo == XO_SUB_CIN);
    rf.mem[src_a] = a;
    rf.mem[src_b] = b;
    e = sub_exp(a, b, (xo == XO_SUB_CIN) ? arith_c_m : 1'b1);
    @(posedge aclk);
    issue_valid <= 1'b1;
    issue_instr <= {oc, dst, src_a, src_b, wr, xo, rec};
    wait_hi(3);
    @(posedge aclk);
    issue_valid <= 1'b0;
    wait_hi(4);
    chk("illegal", {31'h0, !lg}, {31'h0, illegal});
    chk("wb_valid", {31'h0, lg}, {31'h0, wb_valid});
    st_m[IRQ_DONE] = 1'b1;
    st_m[IRQ_ILL] = st_m[IRQ_ILL] | !lg;
    if (lg)
    begin
      chk("wb_addr", {27'h0, dst}, {27'h0, wb_addr});
      chk("wb_data", e[31:0], wb_data);
      legal_n++;
      arith_c_m = e[32];
      wrap_m = wr ? e[33] : wrap_m;
      so_m = so_m | (wr & e[33]);
      st_m[IRQ_WRAP] = st_m[IRQ_WRAP] | (wr & e[33]);
      if (rec) cr_m = {e[31], !e[31] && e[31:0] != 32'h0, e[31:0] == 32'h0, so_m};
    end
    axi_rd(OFF_EXC);
    chk("exc", {29'h0, so_m, wrap_m, arith_c_m}, d);
    axi_rd(OFF_CR0);
    chk("cr0", {28'h0, cr_m}, d);
  endtask : op

  initial
  begin
    #900000;
    tmo("run");
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      axi_rd(8'(4 * i));
      chk("reset value", (i == 0) ? 32'h1 : 32'h0, d);
      chk("reset rresp", {30'h0, RESP_OKAY}, {30'h0, resp});
    end
    axi_rd(8'h18);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    chk("unmapped rdata", 32'h0, d);
    axi_wr(8'h1c, 32'hffffffff);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    // Documented worked examples and edge values first
    for (int i = 0; i < 6; i++)
    begin
      setx({so_m, wrap_m, CT[i][64]});
      op(OPCD_ARITH, CT[i][73:65], 1'b1, 1'b1, CT[i][63:32], CT[i][31:0]);
    end
    for (int i = 0; i < 60; i++)
    begin
      t = rnd();
      if (i % 8 == 0) setx(t[18:16]);
      op(OPCD_ARITH, t[0] ? XO_SUB_CIN : XO_SUB_COUT, t[1], t[2], rnd(), rnd());
    end
    // Plain subtract and a foreign opcode must raise illegal and leave flags and condition field 0 unchanged
    op(OPCD_ARITH, 9'h028, 1'b1, 1'b1, rnd(), rnd());
    op(6'h1e, XO_SUB_COUT, 1'b1, 1'b1, rnd(), rnd());
    axi_wr(OFF_CTRL, 32'h0);
    @(negedge aclk);
    chk("issue_ready disabled", 32'h0, {31'h0, issue_ready});
    axi_wr(OFF_CTRL, 32'h1);
    @(negedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    axi_wr(OFF_IRQ_MASK, 32'h7);
    @(negedge aclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    axi_rd(OFF_IRQ_STAT);
    chk("irq status", {29'h0, st_m}, d);
    axi_wr(OFF_IRQ_STAT, 32'h7);
    st_m = 3'h0;
    @(negedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    axi_wr(OFF_IRQ_MASK, 32'h2);
    op(OPCD_ARITH, XO_SUB_COUT, 1'b0, 1'b0, rnd(), rnd());
    @(negedge aclk);
    chk("irq done masked", 32'h0, {31'h0, irq});
    axi_rd(OFF_COUNT);
    chk("count", 32'(legal_n), d);
    wrap_up();
  end
endmodule : subtract_carry_alu_tb_top

`default_nettype wire
